//--- mcdc_pkg.sv
// Shared constants and types for the device command register block
package mcdc_pkg;
	localparam logic [7:0] REG_OFFSET = 8'hea;
	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam int STORE_BIT = 31;
	localparam int LOAD_BIT = 30;
	localparam int FLT_CLR_BIT = 29;
	localparam int RETRY_CLR_BIT = 28;
	localparam int KEY_HI = 27;
	localparam int KEY_LO = 20;
	localparam int ANGLE_HI = 19;
	localparam int ANGLE_LO = 11;
	localparam int KEEPALIVE_BIT = 10;
	localparam logic [8:0] DEG_FULL = 9'h168;
	localparam logic [7:0] NVM_OP_CYCLES = 8'h10;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} mcdc_req_type;

	typedef struct packed {
		logic fault_clear;
		logic retry_counter_clear;
		logic keepalive;
	} mcdc_pulse_type;
endpackage : mcdc_pkg

//--- mcdc_nvm_seq.sv
// Sequencer for non-volatile store and load operations
module mcdc_nvm_seq (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic start_store,
	input wire logic start_load,
	input wire logic key_ok,
	output logic busy,
	output logic store_pulse,
	output logic load_pulse
);
	typedef enum logic [1:0] {
		IDLE = 2'b00,
		STORE = 2'b01,
		LOAD = 2'b10
	} mcdc_seq_type;

	mcdc_seq_type st_r, st_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic sp_r, sp_nxt, lp_r, lp_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sp_nxt = 1'b0;
		lp_nxt = 1'b0;
		unique case (st_r)
			IDLE: begin
				cnt_nxt = mcdc_pkg::NVM_OP_CYCLES;
				// Store only with a valid unlock key
				if (start_store && key_ok) begin
					st_nxt = STORE;
					sp_nxt = 1'b1;
				end else if (start_load) begin
					st_nxt = LOAD;
					lp_nxt = 1'b1;
				end
			end
			STORE, LOAD: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					st_nxt = IDLE;
				end
			end
			default: st_nxt = IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= IDLE;
			cnt_r <= 8'h00;
			sp_r <= 1'b0;
			lp_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sp_r <= sp_nxt;
			lp_r <= lp_nxt;
		end
	end

	assign busy = (st_r != IDLE);
	assign store_pulse = sp_r;
	assign load_pulse = lp_r;
endmodule : mcdc_nvm_seq

//--- mcdc_top.sv
// Device command and control register with its command side effects
// What this block does
// - Store bit 31 writes config to NVM
// - Load bit 30 reloads defaults from NVM
// - Bits 29/28 clear faults and retry count
// - Key bits 27:20 gate NVM writes
// - Angle bits 19:11, applied modulo 360
// - Device self-clears keepalive bit after write
// - Offset 0xea, reset zero, bits 9:0 zero
// - Forced angle used only when source selected
module mcdc_top (
	input wire logic sys_clk,
	input wire logic rst_b,
	input mcdc_pkg::mcdc_req_type req,
	input wire logic [7:0] nvm_key_expected,
	input wire logic align_angle_source_select,
	input wire logic [8:0] normal_align_angle,
	output logic [31:0] rdata,
	output logic fault_clear,
	output logic retry_counter_clear,
	output logic keepalive_seen,
	output logic nvm_store_request,
	output logic nvm_load_request,
	output logic nvm_store_start,
	output logic nvm_load_start,
	output logic [8:0] align_angle
);
	////////////////////////////////////////////////////////////////
	logic hit;
	logic store_r, store_nxt, load_r, load_nxt;
	logic [7:0] key_r, key_nxt;
	logic [8:0] ang_r, ang_nxt, align_nxt, align_r;
	logic keep_r, keep_nxt;
	mcdc_pkg::mcdc_pulse_type pul_r, pul_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic busy, sp, lp;
	logic key_ok, nvm_done, seq_free, store_refused;
	logic was_busy_r, was_busy_nxt;

	function automatic logic [8:0] mod360(input logic [8:0] a);
		mod360 = (a >= mcdc_pkg::DEG_FULL) ? a - mcdc_pkg::DEG_FULL : a;
	endfunction : mod360

	// Unlisted offsets are simply ignored
	assign hit = (req.addr == mcdc_pkg::REG_OFFSET);
	assign key_ok = (key_r == nvm_key_expected);
	// Busy just fell: the finished request must not start again
	assign nvm_done = was_busy_r && !busy;
	assign seq_free = !busy && !sp && !lp && !nvm_done;
	assign store_refused = store_r && seq_free && !key_ok;

	mcdc_nvm_seq u_seq (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.start_store(store_r && seq_free),
		.start_load(load_r && !store_r && seq_free),
		.key_ok(key_ok),
		.busy(busy),
		.store_pulse(sp),
		.load_pulse(lp)
	);

	////////////////////////////////////////////////////////////////
	always_comb begin
		store_nxt = store_r;
		load_nxt = load_r;
		key_nxt = key_r;
		ang_nxt = ang_r;
		keep_nxt = 1'b0;
		pul_nxt = '0;
		was_busy_nxt = busy;
		if (hit && req.wr) begin
			store_nxt = req.wdata[mcdc_pkg::STORE_BIT];
			load_nxt = req.wdata[mcdc_pkg::LOAD_BIT];
			pul_nxt.fault_clear = req.wdata[mcdc_pkg::FLT_CLR_BIT];
			pul_nxt.retry_counter_clear =
				req.wdata[mcdc_pkg::RETRY_CLR_BIT];
			key_nxt = req.wdata[mcdc_pkg::KEY_HI:mcdc_pkg::KEY_LO];
			ang_nxt = req.wdata[mcdc_pkg::ANGLE_HI:mcdc_pkg::ANGLE_LO];
			keep_nxt = req.wdata[mcdc_pkg::KEEPALIVE_BIT];
			pul_nxt.keepalive = req.wdata[mcdc_pkg::KEEPALIVE_BIT];
		end else if (nvm_done) begin
			// Operation finished: both requests fall together
			store_nxt = 1'b0;
			load_nxt = 1'b0;
		end else if (store_refused) begin
			// Wrong key: drop the store, a pending load may follow
			store_nxt = 1'b0;
		end
		// Forced angle only when source select is one
		align_nxt = align_angle_source_select ? mod360(ang_r)
			: mod360(normal_align_angle);
		rd_nxt = '0;
		if (hit && req.rd) begin
			// Write-only fields and reserved bits read zero
			rd_nxt[mcdc_pkg::STORE_BIT] = store_r;
			rd_nxt[mcdc_pkg::LOAD_BIT] = load_r;
			rd_nxt[mcdc_pkg::KEEPALIVE_BIT] = keep_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			store_r <= 1'b0;
			load_r <= 1'b0;
			key_r <= 8'h00;
			ang_r <= 9'h000;
			keep_r <= 1'b0;
			pul_r <= '0;
			rd_r <= mcdc_pkg::REG_RESET;
			align_r <= 9'h000;
			was_busy_r <= 1'b0;
		end else begin
			was_busy_r <= was_busy_nxt;
			store_r <= store_nxt;
			load_r <= load_nxt;
			key_r <= key_nxt;
			ang_r <= ang_nxt;
			keep_r <= keep_nxt;
			pul_r <= pul_nxt;
			rd_r <= rd_nxt;
			align_r <= align_nxt;
		end
	end

	assign rdata = rd_r;
	assign fault_clear = pul_r.fault_clear;
	assign retry_counter_clear = pul_r.retry_counter_clear;
	assign keepalive_seen = pul_r.keepalive;
	assign nvm_store_request = store_r;
	assign nvm_load_request = load_r;
	assign nvm_store_start = sp;
	assign nvm_load_start = lp;
	assign align_angle = align_r;

	////////////////////////////////////////////////////////////////
	sequence s_store_wr;
		hit && req.wr && req.wdata[31];
	endsequence

	a_store_req_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_store_wr |=> store_r)
		else $error("store request not captured");
	a_load_req_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
		hit && req.wr && req.wdata[30] |=> load_r)
		else $error("load request not captured");
	a_fault_clr_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
		hit && req.wr |=> fault_clear == $past(req.wdata[29]))
		else $error("fault clear pulse wrong");
	a_retry_clr_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
		hit && req.wr |=> retry_counter_clear == $past(req.wdata[28]))
		else $error("retry clear pulse wrong");
	a_key_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
		sp |-> $past(key_r == nvm_key_expected))
		else $error("store started without key");
	a_angle_range: assert property (@(posedge sys_clk) disable iff (!rst_b)
		align_angle < 9'h168)
		else $error("align angle out of range");
	a_keep_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
		keep_r && !(hit && req.wr) |=> !keep_r)
		else $error("keepalive not self cleared");
	a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
		rdata[9:0] == 10'h000 && rdata[29:11] == 19'h00000)
		else $error("reserved or write-only bits read nonzero");
	a_src_select: assert property (@(posedge sys_clk) disable iff (!rst_b)
		align_angle_source_select && $stable(ang_r) ##1
		align_angle_source_select && $stable(ang_r)
		|-> align_angle == mod360(ang_r))
		else $error("forced angle source ignored");
endmodule : mcdc_top

//--- mcdc_host_model.sv
// Host-side model driving the device command register accesses
module mcdc_host_model (
	input wire logic sys_clk,
	output mcdc_pkg::mcdc_req_type req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial req = '0;
	////////////////////////////////////////////////////////////////////
	// Strobe lasts one cycle; address and data flip once it is released,
	// so the device cannot lean on stale values
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(negedge sys_clk);
		req.wr = w;
		req.rd = !w;
		req.addr = a;
		req.wdata = d;
		@(negedge sys_clk);
		req.wr = 1'b0;
		req.rd = 1'b0;
		req.addr = ~a;
		req.wdata = ~d;
	endtask : acc
endmodule : mcdc_host_model

//--- tb_mcdc_top.sv
// Self-checking testbench for the device command register block
module tb_mcdc_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] KEY = 8'h5a;
	localparam logic [7:0] A = mcdc_pkg::REG_OFFSET;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic sel = 1'b1;
	mcdc_pkg::mcdc_req_type req;
	logic [31:0] rdata;
	logic fc, rc, ka, sreq, lreq, sst, lst;
	logic [8:0] ang;
	int err_count = 0;
	int num_checks = 0;
	always #25 sys_clk = ~sys_clk;
	mcdc_host_model host (.sys_clk(sys_clk), .req(req));
	mcdc_top uut (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
		.nvm_key_expected(KEY), .align_angle_source_select(sel),
		.normal_align_angle(9'h02d), .rdata(rdata), .fault_clear(fc),
		.retry_counter_clear(rc), .keepalive_seen(ka),
		.nvm_store_request(sreq), .nvm_load_request(lreq),
		.nvm_store_start(sst), .nvm_load_start(lst), .align_angle(ang));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rd_chk(input string n, input logic [31:0] e);
		host.acc(1'b0, A, 32'h0);
		chk(n, e, rdata);
	endtask : rd_chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(negedge sys_clk);
		rst_b = 1'b1;
		rd_chk("reset value", mcdc_pkg::REG_RESET);
		// Reserved bits written high too
		host.acc(1'b1, A, 32'h300007ff);
		chk("pulses", 32'h7, {29'h0, fc, rc, ka});
		rd_chk("readback", 32'h0);
		$display("test commands done");
		host.acc(1'b1, A, 32'h000c8000);
		repeat (2) @(negedge sys_clk);
		chk("angle 400", 32'h28, 32'(ang));
		sel = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("normal angle", 32'h2d, 32'(ang));
		$display("test angle done");
		host.acc(1'b1, A, {4'h8, KEY, 20'h0});
		chk("store req", 32'h1, 32'(sreq));
		@(negedge sys_clk);
		chk("store start", 32'h1, 32'(sst));
		// Unlisted offset is only read, never written
		host.acc(1'b0, 8'hec, 32'h0);
		chk("other offset", 32'h0, rdata);
		repeat (14) @(negedge sys_clk);
		chk("store held", 32'h1, 32'(sreq));
		@(negedge sys_clk);
		chk("store done", 32'h0, 32'(sreq));
		host.acc(1'b1, A, 32'h40000000);
		chk("load req", 32'h1, 32'(lreq));
		@(negedge sys_clk);
		chk("load start", 32'h1, 32'(lst));
		repeat (17) @(negedge sys_clk);
		chk("load done", 32'h0, 32'(lreq));
		host.acc(1'b1, A, 32'h80000000);
		@(negedge sys_clk);
		chk("bad key", 32'h0, 32'(sst));
		repeat (4) @(negedge sys_clk);
		chk("bad key drop", 32'h0, 32'(sreq));
		$display("test nvm done");
		print_verdict();
	end
endmodule : tb_mcdc_top
